// *** hdl/tlic_defines.svh ***
/*
 two-level interrupt controller: offsets, field positions, reset values
 a write mask and vectors as macros.
 assumes: included by bare name from the top design file and the testbench.
*/
// Operation
// - high vector sits at 000008h, low vector at 000018h
// - a pending high event preempts a low service routine in progress
// - two-level mode only while priority_mode_enable is set; default is compatible
// - priority mode: bit 7 enables high sources, bit 6 enables low sources
// - flag, enable and matching global enable all set gives an immediate vector
// - compatible mode ignores priority bits; every interrupt goes to 000008h
// - compatible mode: bit 6 enables peripheral sources, bit 7 enables all
// - on acceptance clear the global enable that applies to the source
// - no low interrupt is accepted while a high one is serviced
// - on entry push the return address and load the vector into the pc
// - return from interrupt leaves the routine and sets the enable again
// - external and port-change events reach the vector in three to four cycles
// - flags set on their condition regardless of any enable
// - port-change flag sets when any of port b pins 7:4 changes
// - timer-0 and ext-0 flags set by their events, never cleared by hardware
// - second register bits 6,5,4 pick edges of ext 0,1,2: one rising
// - second register bit 2 is timer-0 priority, bit 0 port-change priority
// - second register bit 7 set disables all port b pull-ups
// - second register bits 3 and 1 ignore writes and read zero
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

`define TLIC_ADDR_MAIN 2'h0
`define TLIC_ADDR_EDGE 2'h1
`define TLIC_ADDR_RESET_CONTROL_REGISTER 2'h2
`define TLIC_ADDR_STAT 2'h3

`define TLIC_MAIN_RESET 8'h00
`define TLIC_EDGE_RESET 8'hF5
`define TLIC_EDGE_MASK 8'hF5

`define TLIC_VEC_HIGH 21'h000008
`define TLIC_VEC_LOW 21'h000018

`define TLIC_B_GIEH 7
`define TLIC_B_GIEL 6
`define TLIC_B_T0E 5
`define TLIC_B_X0E 4
`define TLIC_B_PCE 3
`define TLIC_B_T0F 2
`define TLIC_B_X0F 1
`define TLIC_B_PCF 0
`define TLIC_B_PUD 7
`define TLIC_B_EDG0 6
`define TLIC_B_EDG1 5
`define TLIC_B_EDG2 4
`define TLIC_B_T0P 2
`define TLIC_B_PCP 0
`define TLIC_B_PRIORITY_MODE_ENABLE 7

`endif

// *** hdl/tlic_pkg.sv ***
/*
 types for the two-level interrupt controller.
 assumes: compiled before the design modules.
*/
package tlic_pkg;
   typedef enum logic [2:0] {
      TLIC_IDLE = 3'b001,
      TLIC_LOW = 3'b010,
      TLIC_HIGH = 3'b100
   } tlic_state_t;
endpackage

// *** hdl/tlic_edge.sv ***
/*
 pin synchroniser and edge detector for one input.
 assumes: pin is asynchronous to clk; pulse is one cycle per selected edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tlic_edge (
   input wire logic clk, // core clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic pin, // asynchronous pin
   input wire logic rising, // 1 rising, 0 falling, 'x' any when both set
   input wire logic any_edge, // detect both edges
   output logic level, // synchronised level
   output logic pulse // one-cycle edge pulse
);
   logic meta;
   logic sync;
   logic prev;
   logic [2:0] warm; // fills with ones once meta, sync and prev hold real samples
   // two flops, then a delay for the edge compare
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
         warm <= 3'h0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
         warm <= {warm[1:0], 1'b1};
      end
   end
   assign level = sync;
   // edge selection from the synchronised level only
   // no pulse until the pipe is full, so a pin idling high gives no false edge
   assign pulse = warm[2] & (any_edge ? (sync ^ prev) : (rising ? (sync & ~prev) : (~sync & prev)));
endmodule
`default_nettype wire

// *** hdl/tlic_top.sv ***
/*
 two-level interrupt controller: main and edge/priority control registers,
 reset-control priority bit, request gating, vector choice, entry and return.
 assumes: core pulses enter_ack when it takes the vector (pushing the return
 address and loading the pc) and ret_exec on return from interrupt; software
 reaches registers over a plain strobe port on clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.svh"
module tlic_top
   import tlic_pkg::*;
(
   input wire logic clk, // core clock, 200 MHz
   input wire logic rst_b, // synchronous reset, active low
   input wire logic [1:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic [2:0] ext_pin, // external interrupt pins 0..2
   input wire logic [3:0] portb_hi, // port b pins 7:4
   input wire logic timer0_ovf, // timer-0 overflow pulse, same clock
   input wire logic periph_req, // combined peripheral request, same clock
   input wire logic periph_high, // peripheral request routed high
   input wire logic [20:0] pc_current, // return address from core
   output logic irq, // interrupt request to sequencer
   output logic [20:0] vector_addr, // selected vector
   input wire logic enter_ack, // core takes the vector, pulse
   input wire logic ret_exec, // return from interrupt executed, pulse
   output logic push_stack, // push return address, pulse
   output logic [20:0] push_addr, // return address to push
   output logic load_pc, // load pc with vector_addr, pulse
   output logic [2:0] ext_edge_pulse, // edge events of ext 0..2 for other flag regs
   output logic pullup_disable // all port b pull-ups disabled
);
   logic [7:0] interrupt_control_main;
   logic [7:0] interrupt_control_edge_prio;
   logic priority_mode_enable;
   tlic_state_t state;
   tlic_state_t next_state;
   logic in_low_nested; // high preempted a low routine
   logic [2:0] ext_level;
   logic [3:0] pb_level;
   logic [3:0] pb_pulse;
   logic [2:0] edge_sel;
   logic [2:0] armed; // fills after reset; pin checks wait for it

   // pins synchronised and edge detected per input
   assign edge_sel = interrupt_control_edge_prio[6:4];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ext
         tlic_edge u_ext (
            .clk(clk),
            .rst_b(rst_b),
            .pin(ext_pin[gi]),
            .rising(edge_sel[2 - gi]),
            .any_edge(1'b0),
            .level(ext_level[gi]),
            .pulse(ext_edge_pulse[gi])
         );
      end
      for (gi = 0; gi < 4; gi++) begin : g_pb
         tlic_edge u_pb (
            .clk(clk),
            .rst_b(rst_b),
            .pin(portb_hi[gi]),
            .rising(1'b1),
            .any_edge(1'b1),
            .level(pb_level[gi]),
            .pulse(pb_pulse[gi])
         );
      end
   endgenerate

   // decoded writes
   wire wr_main = wr && (addr == `TLIC_ADDR_MAIN);
   wire wr_edge = wr && (addr == `TLIC_ADDR_EDGE);
   wire wr_reset_control_register = wr && (addr == `TLIC_ADDR_RESET_CONTROL_REGISTER);

   // source events
   wire ev_t0 = timer0_ovf;
   wire ev_x0 = ext_edge_pulse[0];
   wire ev_pc = |pb_pulse;

   // requests: flag and enable
   wire req_t0 = interrupt_control_main[`TLIC_B_T0F] & interrupt_control_main[`TLIC_B_T0E];
   wire req_x0 = interrupt_control_main[`TLIC_B_X0F] & interrupt_control_main[`TLIC_B_X0E];
   wire req_pc = interrupt_control_main[`TLIC_B_PCF] & interrupt_control_main[`TLIC_B_PCE];
   wire pri_t0 = interrupt_control_edge_prio[`TLIC_B_T0P];
   wire pri_pc = interrupt_control_edge_prio[`TLIC_B_PCP];

   // priority routing; ext-0 is always high
   wire any_high = req_x0 | (req_t0 & pri_t0) | (req_pc & pri_pc) | (periph_req & periph_high);
   wire any_low = (req_t0 & ~pri_t0) | (req_pc & ~pri_pc) | (periph_req & ~periph_high);
   wire gieh = interrupt_control_main[`TLIC_B_GIEH];
   wire giel = interrupt_control_main[`TLIC_B_GIEL];

   // priority mode gates high and low separately
   wire take_high_p = any_high & gieh & (state != TLIC_HIGH);
   wire take_low_p = any_low & giel & gieh & (state == TLIC_IDLE);
   // compatible mode: bit 7 all, bit 6 peripherals; priority ignored
   wire take_compat = gieh & (req_t0 | req_x0 | req_pc | (periph_req & giel));
   wire go_high = priority_mode_enable ? take_high_p : take_compat;
   wire go_low = priority_mode_enable & ~take_high_p & take_low_p;

   assign irq = go_high | go_low;
   assign vector_addr = go_high ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW;
   wire accept = irq & enter_ack;
   assign push_stack = accept;
   assign load_pc = accept;
   assign push_addr = pc_current;

   // service state: which level is running
   always_comb begin
      next_state = state;
      case (state)
         TLIC_IDLE: begin
            if (accept) next_state = go_high ? TLIC_HIGH : TLIC_LOW;
         end
         TLIC_LOW: begin
            if (accept && go_high) next_state = TLIC_HIGH;
            else if (ret_exec) next_state = TLIC_IDLE;
         end
         TLIC_HIGH: begin
            if (ret_exec) next_state = in_low_nested ? TLIC_LOW : TLIC_IDLE;
         end
         default: next_state = TLIC_IDLE;
      endcase
   end

   // which enable the return restores
   wire ret_high = ret_exec & (~priority_mode_enable | (state == TLIC_HIGH));
   wire ret_low = ret_exec & priority_mode_enable & (state == TLIC_LOW);
   wire clr_high = accept & go_high;
   wire clr_low = accept & go_low;

   // next main register: hardware sets win over software writes
   logic [7:0] next_main;
   always_comb begin
      next_main = wr_main ? wdata : interrupt_control_main;
      if (clr_high) next_main[`TLIC_B_GIEH] = 1'b0;
      if (clr_low) next_main[`TLIC_B_GIEL] = 1'b0;
      if (ret_high) next_main[`TLIC_B_GIEH] = 1'b1;
      if (ret_low) next_main[`TLIC_B_GIEL] = 1'b1;
      if (ev_t0) next_main[`TLIC_B_T0F] = 1'b1;
      if (ev_x0) next_main[`TLIC_B_X0F] = 1'b1;
      if (ev_pc) next_main[`TLIC_B_PCF] = 1'b1;
   end

   // register and state update
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         interrupt_control_main <= `TLIC_MAIN_RESET;
         interrupt_control_edge_prio <= `TLIC_EDGE_RESET;
         priority_mode_enable <= 1'b0;
         state <= TLIC_IDLE;
         in_low_nested <= 1'b0;
         armed <= 3'h0;
      end else begin
         interrupt_control_main <= next_main;
         if (wr_edge) interrupt_control_edge_prio <= wdata & `TLIC_EDGE_MASK;
         if (wr_reset_control_register) priority_mode_enable <= wdata[`TLIC_B_PRIORITY_MODE_ENABLE];
         state <= next_state;
         armed <= {armed[1:0], 1'b1};
         if (state == TLIC_LOW && next_state == TLIC_HIGH) in_low_nested <= 1'b1;
         else if (state == TLIC_HIGH && ret_exec) in_low_nested <= 1'b0;
      end
   end

   assign pullup_disable = interrupt_control_edge_prio[`TLIC_B_PUD];

   // read data mux
   wire [7:0] rd_mux = (addr == `TLIC_ADDR_MAIN) ? interrupt_control_main :
      (addr == `TLIC_ADDR_EDGE) ? interrupt_control_edge_prio :
      (addr == `TLIC_ADDR_RESET_CONTROL_REGISTER) ? {priority_mode_enable, 7'h00} :
      {1'b0, ext_level, pb_level[3:0] & 4'hF};
   always_ff @(posedge clk) begin
      if (!rst_b) rdata <= 8'h00;
      else rdata <= rd ? rd_mux : 8'h00;
   end

   // assertions
   vector_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      irq && !priority_mode_enable |-> vector_addr == 21'h000008)
      else $error("compatible mode vector not high");
   no_low_in_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      state == TLIC_HIGH |-> !go_low)
      else $error("low accepted during high service");
   high_preempt_a: assert property (@(posedge clk) disable iff (!rst_b)
      state == TLIC_LOW && priority_mode_enable && any_high && gieh |-> irq)
      else $error("high did not preempt low");
   entry_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      accept && go_high && !ret_exec |=> !interrupt_control_main[7])
      else $error("high enable not cleared on entry");
   ret_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      ret_exec && !priority_mode_enable |=> interrupt_control_main[7])
      else $error("enable not restored on return");
   flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      ev_t0 |=> interrupt_control_main[2])
      else $error("timer flag not set");
   ext_latency_a: assert property (@(posedge clk) disable iff (!rst_b)
      armed[2] && $rose(ext_level[0]) && edge_sel[2] |=> interrupt_control_main[1])
      else $error("ext flag late");
   port_change_a: assert property (@(posedge clk) disable iff (!rst_b)
      armed[2] && $changed(pb_level) |=> interrupt_control_main[0])
      else $error("port change flag not set");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      (interrupt_control_edge_prio & 8'h0A) == 8'h00)
      else $error("reserved bits not zero");
   request_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      irq |-> gieh)
      else $error("request without global enable");

   // vectors and modes
   low_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
      go_low
      |-> vector_addr == 21'h000018)
      else $error("low vector wrong");

   compat_single_a: assert property (@(posedge clk) disable iff (!rst_b)
      !priority_mode_enable
      |-> !go_low)
      else $error("low vector used in compatible mode");

   compat_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      !priority_mode_enable && !gieh
      |-> !irq)
      else $error("request while all disabled");

   compat_periph_a: assert property (@(posedge clk) disable iff (!rst_b)
      !priority_mode_enable && !giel && periph_req && !req_t0 && !req_x0 && !req_pc
      |-> !irq)
      else $error("peripheral request passed a closed gate");

   low_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      go_low
      |-> giel)
      else $error("low taken without low enable");

   high_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
      priority_mode_enable && req_t0 && pri_t0 && gieh && state != TLIC_HIGH
      |-> irq && vector_addr == 21'h000008)
      else $error("high source not vectored at once");

   prio_route_a: assert property (@(posedge clk) disable iff (!rst_b)
      priority_mode_enable && req_pc && !pri_pc && !any_high && giel && gieh
      && state == TLIC_IDLE |-> go_low)
      else $error("low port change not routed low");

   // entry, nesting and return
   low_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      accept && go_low && !ret_exec
      |=> !interrupt_control_main[6])
      else $error("low enable not cleared on entry");

   low_state_a: assert property (@(posedge clk) disable iff (!rst_b)
      accept && go_low
      |-> state == TLIC_IDLE)
      else $error("low accepted while a routine runs");

   preempt_state_a: assert property (@(posedge clk) disable iff (!rst_b)
      state == TLIC_LOW && accept && go_high
      |=> state == TLIC_HIGH && in_low_nested)
      else $error("preemption not recorded");

   nest_return_a: assert property (@(posedge clk) disable iff (!rst_b)
      state == TLIC_HIGH && in_low_nested && ret_exec
      |=> state == TLIC_LOW)
      else $error("nested return lost the low routine");

   push_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      accept
      |-> push_stack && load_pc && push_addr == pc_current)
      else $error("entry without push and load");

   no_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
      !enter_ack
      |-> !load_pc && !push_stack)
      else $error("push or load without core acknowledge");

   high_ret_a: assert property (@(posedge clk) disable iff (!rst_b)
      ret_exec && priority_mode_enable && state == TLIC_HIGH
      |=> interrupt_control_main[7])
      else $error("high enable not restored");

   low_ret_a: assert property (@(posedge clk) disable iff (!rst_b)
      ret_exec && priority_mode_enable && state == TLIC_LOW
      |=> interrupt_control_main[6])
      else $error("low enable not restored");

   // flags
   ext_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
      armed[2] && $fell(ext_level[0]) && !edge_sel[2]
      |=> interrupt_control_main[1])
      else $error("ext falling flag late");

   ext_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
      ev_x0
      |=> interrupt_control_main[1])
      else $error("ext flag not set");

   t0_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      interrupt_control_main[2] && !wr_main
      |=> interrupt_control_main[2])
      else $error("timer flag cleared by hardware");

   x0_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      interrupt_control_main[1] && !wr_main
      |=> interrupt_control_main[1])
      else $error("ext flag cleared by hardware");

   pc_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      interrupt_control_main[0] && !wr_main
      |=> interrupt_control_main[0])
      else $error("port change flag cleared by hardware");

   // registers
   main_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_main && !accept && !ret_exec && !ev_t0 && !ev_x0 && !ev_pc
      |=> interrupt_control_main == $past(wdata))
      else $error("main register write lost");

   edge_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_edge
      |=> interrupt_control_edge_prio == ($past(wdata) & 8'hF5))
      else $error("edge register write wrong");

   reset_control_register_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_reset_control_register
      |=> priority_mode_enable == $past(wdata[7]))
      else $error("priority mode bit write lost");

   pullup_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1
      |-> pullup_disable == interrupt_control_edge_prio[7])
      else $error("pull-up disable not from its bit");

   cover_high: cover property (@(posedge clk) accept && go_high);
   cover_low: cover property (@(posedge clk) accept && go_low);
   cover_nest: cover property (@(posedge clk) state == TLIC_LOW && next_state == TLIC_HIGH);
   cover_compat: cover property (@(posedge clk) accept && !priority_mode_enable);
   cover_ext_rise: cover property (@(posedge clk) ev_x0 && edge_sel[2]);
endmodule
`default_nettype wire

// *** verification/tlic_core_model.sv ***
/*
 core sequencer model: takes vectors, checks the push, returns on request.
 assumes: same clock as tlic_top; bench pulses ret_req for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model (
   input wire logic clk, // core clock
   input wire logic rst_b, // reset, active low
   input wire logic irq, // request from controller
   input wire logic slow, // take requests a cycle later
   input wire logic load_pc, // vector load pulse
   input wire logic push_stack, // push pulse
   input wire logic [20:0] vector_addr, // offered vector
   input wire logic [20:0] push_addr, // address to push
   input wire logic ret_req, // bench asks for a return
   output logic enter_ack, // vector taken
   output logic ret_exec, // return executed
   output logic [20:0] pc_current, // running pc
   output logic [20:0] last_vec, // last vector loaded
   output logic push_ok, // every push carried the pc
   output var int takes // vectors taken
);
   logic irq_seen;
   // take a standing request once, promptly or one cycle late
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enter_ack <= 1'b0;
         irq_seen <= 1'b0;
         ret_exec <= 1'b0;
         pc_current <= 21'h000100;
         last_vec <= 21'h000000;
         push_ok <= 1'b1;
         takes <= 0;
      end else begin
         irq_seen <= irq & ~enter_ack;
         enter_ack <= irq & ~enter_ack & (~slow | irq_seen);
         ret_exec <= ret_req;
         pc_current <= pc_current + 21'h000002;
         if (load_pc) begin
            last_vec <= vector_addr;
            takes <= takes + 1;
            push_ok <= push_ok & push_stack & (push_addr === pc_current);
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
/*
 self-checking bench for tlic_top with the core model.
 assumes: design files and tlic_core_model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.svh"
module testbench;
   logic clk, rst_b, wr, rd, tovf, ret_req, slow, irq, enter_ack, ret_exec, push, load, pud, ok;
   logic preq;
   logic [1:0] addr;
   logic [7:0] wdata, rdata;
   logic [2:0] ext_pin, edge_p;
   logic [3:0] portb_hi;
   logic [20:0] pc, vec, push_addr, last_vec;
   int takes, mismatches, checks, cyc, n;
   tlic_top i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ext_pin(ext_pin), .portb_hi(portb_hi), .timer0_ovf(tovf),
      .periph_req(preq), .periph_high(1'b0), .pc_current(pc), .irq(irq), .vector_addr(vec),
      .enter_ack(enter_ack), .ret_exec(ret_exec), .push_stack(push), .push_addr(push_addr),
      .load_pc(load), .ext_edge_pulse(edge_p), .pullup_disable(pud));
   tlic_core_model i_core (.clk(clk), .rst_b(rst_b), .irq(irq), .slow(slow), .load_pc(load),
      .push_stack(push), .vector_addr(vec), .push_addr(push_addr), .ret_req(ret_req),
      .enter_ack(enter_ack), .ret_exec(ret_exec), .pc_current(pc), .last_vec(last_vec),
      .push_ok(ok), .takes(takes));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(21'(rdata), 21'(e));
   endtask
   task automatic tick(input logic on_ret);
      @(posedge clk);
      if (on_ret) ret_req <= 1'b1;
      else tovf <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      tovf <= 1'b0;
   endtask
   // wait for one vector fetch and judge it
   task automatic take(input logic [20:0] e);
      int t0;
      t0 = takes;
      repeat (20) if (takes == t0) @(posedge clk);
      #1 chk(21'(takes - t0), 21'h000001);
      chk(last_vec, e);
      chk(21'(ok), 21'h000001);
   endtask
   task automatic t_regs;
      rreg(`TLIC_ADDR_MAIN, 8'h00);
      rreg(`TLIC_ADDR_EDGE, 8'hF5);
      rreg(`TLIC_ADDR_RESET_CONTROL_REGISTER, 8'h00);
      wreg(`TLIC_ADDR_EDGE, 8'hFF);
      rreg(`TLIC_ADDR_EDGE, 8'hF5);
      chk(21'(pud), 21'h000001);
      wreg(`TLIC_ADDR_EDGE, 8'h04);
      rreg(`TLIC_ADDR_EDGE, 8'h04);
      chk(21'(pud), 21'h000000);
   endtask
   task automatic t_poll;
      tick(1'b0);
      rreg(`TLIC_ADDR_MAIN, 8'h04);
      chk(21'(irq), 21'h000000);
      wreg(`TLIC_ADDR_MAIN, 8'h00);
      rreg(`TLIC_ADDR_MAIN, 8'h00);
   endtask
   // high entry, low held off, then low entry after return
   task automatic t_prio;
      wreg(`TLIC_ADDR_RESET_CONTROL_REGISTER, 8'h80);
      wreg(`TLIC_ADDR_MAIN, 8'hA0);
      tick(1'b0);
      take(`TLIC_VEC_HIGH);
      rreg(`TLIC_ADDR_MAIN, 8'h24);
      wreg(`TLIC_ADDR_MAIN, 8'h48);
      n = takes;
      @(posedge clk);
      portb_hi <= 4'h2;
      repeat (10) @(posedge clk);
      chk(21'(takes - n), 21'h000000);
      tick(1'b1);
      take(`TLIC_VEC_LOW);
      rreg(`TLIC_ADDR_MAIN, 8'h89);
   endtask
   // falling edge of ext 0 preempts the low routine
   task automatic t_pre;
      wreg(`TLIC_ADDR_MAIN, 8'h90);
      n = takes;
      @(posedge clk);
      ext_pin <= 3'b001;
      repeat (6) @(posedge clk);
      chk(21'(takes - n), 21'h000000);
      rreg(`TLIC_ADDR_MAIN, 8'h90);
      @(posedge clk);
      ext_pin <= 3'b000;
      for (n = 1; n < 10; n++) begin
         @(posedge clk);
         #1;
         if (irq === 1'b1) break;
      end
      chk(21'(n >= 3 && n <= 4), 21'h000001);
      take(`TLIC_VEC_HIGH);
      wreg(`TLIC_ADDR_MAIN, 8'h00);
      tick(1'b1);
      tick(1'b1);
      rreg(`TLIC_ADDR_MAIN, 8'hC0);
   endtask
   // compatible mode: low priority source still goes to the high vector
   task automatic t_compat;
      slow <= 1'b1;
      wreg(`TLIC_ADDR_RESET_CONTROL_REGISTER, 8'h00);
      wreg(`TLIC_ADDR_EDGE, 8'h00);
      wreg(`TLIC_ADDR_MAIN, 8'hA0);
      tick(1'b0);
      take(`TLIC_VEC_HIGH);
      rreg(`TLIC_ADDR_MAIN, 8'h24);
      wreg(`TLIC_ADDR_MAIN, 8'h00);
      tick(1'b1);
      rreg(`TLIC_ADDR_MAIN, 8'h80);
   endtask
   // compatible mode: bit 6 gates the peripheral source; ext 0 on a rising edge
   task automatic t_periph;
      wreg(`TLIC_ADDR_MAIN, 8'h80);
      @(posedge clk);
      preq <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(21'(irq), 21'h000000);
      wreg(`TLIC_ADDR_MAIN, 8'hC0);
      take(`TLIC_VEC_HIGH);
      @(posedge clk);
      preq <= 1'b0;
      tick(1'b1);
      rreg(`TLIC_ADDR_MAIN, 8'hC0);
      wreg(`TLIC_ADDR_EDGE, 8'h40);
      @(posedge clk);
      ext_pin <= 3'b001;
      for (n = 1; n < 6; n++) begin
         @(posedge clk);
         #1;
         if (edge_p[0] === 1'b1) break;
      end
      chk(21'(n), 21'h000002);
      rreg(`TLIC_ADDR_MAIN, 8'hC2);
      rreg(`TLIC_ADDR_STAT, 8'h12);
   endtask
   initial begin
      rst_b = 1'b0;
      {wr, rd, tovf, ret_req, slow, preq} = 6'h00;
      addr = 2'h0;
      wdata = 8'h00;
      ext_pin = 3'h0;
      portb_hi = 4'h0;
      {mismatches, checks, cyc} = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_poll;
      t_prio;
      t_pre;
      t_compat;
      t_periph;
      wrap_up;
   end
endmodule
`default_nettype wire
